// ### src/core_regs_pkg.sv
/*
 Shared constants, types and decode helpers for the core register bank
 with its indirect data-memory ports.
 Assumes an 8-bit data path and a 12-bit data-memory address.
*/
package core_regs_pkg;

  // Bus and pointer widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PTR_HI_W = 4;
  localparam int NUM_SLOTS = 24;
  localparam int SLOT_W = 5;
  localparam int TBL_W = 22;

  // Bank window: slot index is BANK_TOP minus the address
  localparam logic [11:0] BANK_TOP = 12'hfff;
  localparam logic [11:0] BANK_BASE = 12'hfe8;

  // Register addresses
  localparam logic [11:0] ADDR_TBL_UP = 12'hff8;
  localparam logic [11:0] ADDR_PROD_H = 12'hff4;
  localparam logic [11:0] ADDR_IND_PLAIN = 12'hfef;
  localparam logic [11:0] ADDR_IND_POSTINC = 12'hfee;
  localparam logic [11:0] ADDR_IND_POSTDEC = 12'hfed;
  localparam logic [11:0] ADDR_IND_PREINC = 12'hfec;
  localparam logic [11:0] ADDR_IND_INDEXED = 12'hfeb;

  // Slot indices of registers the logic touches directly
  localparam int IDX_TBL_UP = 7;
  localparam int IDX_TBL_HI = 8;
  localparam int IDX_TBL_LO = 9;
  localparam int IDX_TBL_LAT = 10;
  localparam int IDX_PTR_H = 21;
  localparam int IDX_PTR_L = 22;
  localparam int IDX_WACC = 23;

  // Table pointer upper byte: bit 5 is pointer bit 21
  localparam int TBL_CFG_BIT = 5;

  // Implemented bits per slot, index 23 first; zero slots hold nothing
  localparam logic [NUM_SLOTS-1:0][7:0] SLOT_MASK = {
    8'hff, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff,
    8'h3f, 8'hff, 8'hff, 8'h3f, 8'hdf, 8'hff, 8'hff, 8'h1f};

  // Reset value per slot, index 23 first
  localparam logic [NUM_SLOTS-1:0][7:0] SLOT_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hc0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};

  // Indirect access modes; four-state base so a mode can ride a port net
  typedef enum logic [2:0] {
    IND_NONE,
    IND_PLAIN,
    IND_POST_INC,
    IND_POST_DEC,
    IND_PRE_INC,
    IND_INDEXED
  } ind_mode_t;

  // One register-bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } bus_req_t;

  // Data-memory access
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
  } dmem_req_t;

  // Register state of the bank, all but the product high byte
  typedef struct packed {
    logic [NUM_SLOTS-1:0][7:0] slot;
    logic [DATA_W-1:0] rdata;
  } bank_state_t;

  localparam bank_state_t STATE_RESET = '{slot: SLOT_RESET, rdata: 8'h00};

  // Address to indirect mode
  function automatic ind_mode_t decode_mode(input logic [11:0] a);
    case (a)
      ADDR_IND_PLAIN: decode_mode = IND_PLAIN;
      ADDR_IND_POSTINC: decode_mode = IND_POST_INC;
      ADDR_IND_POSTDEC: decode_mode = IND_POST_DEC;
      ADDR_IND_PREINC: decode_mode = IND_PRE_INC;
      ADDR_IND_INDEXED: decode_mode = IND_INDEXED;
      default: decode_mode = IND_NONE;
    endcase
  endfunction

  // Address inside the stored slot window
  function automatic logic slot_hit(input logic [11:0] a);
    slot_hit = (a >= BANK_BASE);
  endfunction

endpackage

// ### src/dmem_array.sv
/*
 Byte-wide data memory reached through the indirect ports.
 Assumes one clock; write is synchronous, read is combinational so the
 caller can register it in the same cycle as a register read.
*/
`timescale 1ns/100ps
module dmem_array #(
  parameter int AW = 12,
  parameter int DEPTH = 4096
) (
  input wire logic ref_clk_i,
  input wire logic ce_i,
  input wire core_regs_pkg::dmem_req_t req_i,
  output logic [7:0] rdata_o
);
  import core_regs_pkg::*;

  // Every pointer value must land on a real word
  if (DEPTH != (1 << AW) || AW != ADDR_W) begin : g_bad_depth
    $error("dmem_array: DEPTH must be 2**AW and AW the pointer width");
  end

  // Storage; no reset, contents are undefined at power-up
  logic [7:0] mem [DEPTH];

  // Write port, frozen with the clock enable
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && req_i.we) begin
      mem[req_i.addr] <= req_i.wdata;
    end
  end

  // Read port
  assign rdata_o = mem[req_i.addr];

endmodule

// ### src/indirect_addr_unit.sv
/*
 Effective-address and pointer-update arithmetic for the indirect ports.
 Purely combinational; assumes a 12-bit pointer and 8-bit signed offset.
*/
`timescale 1ns/100ps
module indirect_addr_unit (
  input wire core_regs_pkg::ind_mode_t mode_i,
  input wire logic [11:0] ptr_i,
  input wire logic [7:0] offset_i,
  output logic [11:0] eff_addr_o,
  output logic [11:0] next_ptr_o
);
  import core_regs_pkg::*;

  logic [11:0] ptr_inc; // Pointer plus one, wraps at 12 bits
  logic [11:0] ptr_dec; // Pointer minus one, wraps at 12 bits
  logic [11:0] ptr_idx; // Pointer plus signed offset

  assign ptr_inc = ptr_i + 12'h001;
  assign ptr_dec = ptr_i - 12'h001;
  assign ptr_idx = ptr_i + {{(ADDR_W-8){offset_i[7]}}, offset_i};

  // Mode select
  always_comb begin
    eff_addr_o = ptr_i;
    next_ptr_o = ptr_i;
    case (mode_i)
      IND_POST_INC: next_ptr_o = ptr_inc;
      IND_POST_DEC: next_ptr_o = ptr_dec;
      IND_PRE_INC: begin
        eff_addr_o = ptr_inc;
        next_ptr_o = ptr_inc;
      end
      IND_INDEXED: eff_addr_o = ptr_idx;
      default: begin // Plain port: pointer held
        eff_addr_o = ptr_i;
        next_ptr_o = ptr_i;
      end
    endcase
  end

endmodule

// ### src/core_register_file_indirect.sv
/*
 Core register bank with indirect data-memory ports through pointer zero.
 Assumes the instruction core drives the register port on ref_clk_i and
 never raises read and write strobes together.
*/
`timescale 1ns/100ps
module core_register_file_indirect #(
  parameter int DMEM_DEPTH = 4096
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire core_regs_pkg::bus_req_t bus_i,
  output logic [7:0] rd_data_o,
  output logic [21:0] table_pointer_o,
  output logic table_cfg_space_o,
  output logic [7:0] table_transfer_latch_o,
  output logic [7:0] working_accumulator_o
);
  import core_regs_pkg::*;

  // The pointer arithmetic assumes the full 12-bit space
  if (DMEM_DEPTH != (1 << ADDR_W)) begin : g_bad_param
    $error("core_register_file_indirect: DMEM_DEPTH must be 4096");
  end

  bank_state_t st_q; // Registered bank state
  bank_state_t st_d; // Next bank state
  logic [7:0] product_high_q; // Kept out of reset on purpose
  ind_mode_t mode; // Indirect mode of the current address
  logic [11:0] indirect_pointer_zero; // Pointer zero, both bytes
  logic [11:0] eff_addr; // Data-memory address of this access
  logic [11:0] next_ptr; // Pointer value after this access
  logic [7:0] dm_rdata; // Data-memory read value
  dmem_req_t dm_req; // Data-memory request
  logic [SLOT_W-1:0] slot_idx; // Slot addressed by the bus
  logic is_ind; // Address is one of the indirect ports
  logic access; // A read or a write is present

  // Pointer zero assembled from its two bytes
  assign indirect_pointer_zero = {st_q.slot[IDX_PTR_H][PTR_HI_W-1:0],
                                  st_q.slot[IDX_PTR_L]};

  // Decode of the bus address
  assign mode = decode_mode(bus_i.addr);
  assign is_ind = (mode != IND_NONE);
  assign access = bus_i.we | bus_i.re;
  assign slot_idx = SLOT_W'(BANK_TOP - bus_i.addr);

  // Pointer arithmetic for the indirect ports
  indirect_addr_unit u_addr (
    .mode_i(mode),
    .ptr_i(indirect_pointer_zero),
    .offset_i(st_q.slot[IDX_WACC]),
    .eff_addr_o(eff_addr),
    .next_ptr_o(next_ptr)
  );

  // The ports have no storage: writes go straight to data memory
  assign dm_req.addr = eff_addr;
  assign dm_req.wdata = bus_i.wdata;
  assign dm_req.we = bus_i.we & is_ind;

  dmem_array #(
    .AW(ADDR_W),
    .DEPTH(DMEM_DEPTH)
  ) u_dmem (
    .ref_clk_i(ref_clk_i),
    .ce_i(ce_i),
    .req_i(dm_req),
    .rdata_o(dm_rdata)
  );

  // Next-state logic for the bank state struct; the product high byte has its own process
  always_comb begin
    st_d = st_q;
    // Stored register write; masked bits stay zero
    if (bus_i.we && !is_ind && slot_hit(bus_i.addr)) begin
      st_d.slot[slot_idx] = bus_i.wdata & SLOT_MASK[slot_idx];
    end
    // Any indirect access moves the pointer as its mode says. Reads move
    // it as well, so the core must not read a moving port just to look.
    // One address per cycle means a direct pointer write and an indirect
    // move can never meet, so no priority between them is needed.
    if (access && is_ind) begin
      st_d.slot[IDX_PTR_H] = {{(8-PTR_HI_W){1'b0}},
                              next_ptr[ADDR_W-1:8]};
      st_d.slot[IDX_PTR_L] = next_ptr[7:0];
    end
    // Read capture for the cycle after the strobe. Data memory is read
    // through the address before the pointer moves, so the byte and the
    // move land on the same edge.
    if (bus_i.re) begin
      if (is_ind) begin
        st_d.rdata = dm_rdata;
      end else if (bus_i.addr == ADDR_PROD_H) begin
        st_d.rdata = product_high_q;
      end else if (slot_hit(bus_i.addr)) begin
        st_d.rdata = st_q.slot[slot_idx] & SLOT_MASK[slot_idx];
      end else begin
        st_d.rdata = 8'h00; // Outside the bank
      end
    end
  end

  // Bank registers; reset loads the documented values
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= STATE_RESET;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // Product high byte: no reset, so software must not trust it early
  // It sits outside the state struct because that struct is reset
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && bus_i.we && bus_i.addr == ADDR_PROD_H) begin
      product_high_q <= bus_i.wdata;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data_o = st_q.rdata;
  assign table_pointer_o = {st_q.slot[IDX_TBL_UP][TBL_CFG_BIT:0],
                            st_q.slot[IDX_TBL_HI],
                            st_q.slot[IDX_TBL_LO]};
  assign table_cfg_space_o = st_q.slot[IDX_TBL_UP][TBL_CFG_BIT];
  assign table_transfer_latch_o = st_q.slot[IDX_TBL_LAT];
  assign working_accumulator_o = st_q.slot[IDX_WACC];

  // Marks the first edge after reset release, for the checks below
  logic first_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // Checks run on the bank clock and sleep while reset is low; request
  // antecedents carry the clock enable, as a frozen cycle takes nothing
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Plain access leaves the pointer alone
  property p_plain_hold;
    (ce_i && access && mode == IND_PLAIN)
      |=> indirect_pointer_zero == $past(indirect_pointer_zero);
  endproperty
  a_plain_hold: assert property (p_plain_hold)
    else $error("plain port changed the pointer");

  // Post-increment: old address used, pointer one higher
  property p_post_inc;
    (ce_i && access && mode == IND_POST_INC)
      |-> (dm_req.addr == indirect_pointer_zero)
      ##1 (indirect_pointer_zero == 12'($past(dm_req.addr) + 12'h001));
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("post-increment address or update wrong");

  // Post-decrement: old address used, pointer one lower
  property p_post_dec;
    (ce_i && access && mode == IND_POST_DEC)
      |-> (dm_req.addr == indirect_pointer_zero)
      ##1 (indirect_pointer_zero == 12'($past(dm_req.addr) - 12'h001));
  endproperty
  a_post_dec: assert property (p_post_dec)
    else $error("post-decrement address or update wrong");

  // Pre-increment: address is pointer plus one, pointer ends there
  property p_pre_inc;
    (ce_i && access && mode == IND_PRE_INC)
      |-> (dm_req.addr == 12'(indirect_pointer_zero + 12'h001))
      ##1 (indirect_pointer_zero == $past(dm_req.addr));
  endproperty
  a_pre_inc: assert property (p_pre_inc)
    else $error("pre-increment address or update wrong");

  // Table pointer low byte and table latch are zero after reset
  property p_tbl_low_reset;
    first_q |-> table_pointer_o[7:0] == 8'h00;
  endproperty
  a_tbl_low_reset: assert property (p_tbl_low_reset)
    else $error("table pointer low byte not cleared by reset");

  property p_latch_reset;
    first_q |-> table_transfer_latch_o == 8'h00;
  endproperty
  a_latch_reset: assert property (p_latch_reset)
    else $error("table latch not cleared by reset");

  // Product high byte reads back what was written
  sequence s_prod_write;
    ce_i && bus_i.we && bus_i.addr == ADDR_PROD_H;
  endsequence
  sequence s_prod_read;
    ce_i && bus_i.re && bus_i.addr == ADDR_PROD_H;
  endsequence
  property p_prod_readback;
    s_prod_write ##1 s_prod_read |=> rd_data_o == $past(bus_i.wdata, 2);
  endproperty
  a_prod_readback: assert property (p_prod_readback)
    else $error("product high byte read back wrong");

  // Indexed: pointer plus signed accumulator, pointer kept
  property p_indexed;
    (ce_i && access && mode == IND_INDEXED)
      |-> (dm_req.addr == 12'(indirect_pointer_zero
           + {{(ADDR_W-8){working_accumulator_o[7]}},
              working_accumulator_o}))
      ##1 (indirect_pointer_zero == $past(indirect_pointer_zero));
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed port address or pointer wrong");

  // Writing bit 21 steers table accesses to configuration space
  property p_cfg_select;
    (ce_i && bus_i.we && bus_i.addr == ADDR_TBL_UP)
      |=> table_cfg_space_o == $past(bus_i.wdata[TBL_CFG_BIT]);
  endproperty
  a_cfg_select: assert property (p_cfg_select)
    else $error("configuration select does not follow write");

  // Reads outside the bank give zero
  property p_unmapped_zero;
    (ce_i && bus_i.re && !slot_hit(bus_i.addr)) |=> rd_data_o == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  // Absent bits of a stored register always read back as zero
  property p_absent_bits;
    (ce_i && bus_i.re && !is_ind && slot_hit(bus_i.addr)
     && bus_i.addr != ADDR_PROD_H)
      |=> (rd_data_o & ~$past(SLOT_MASK[slot_idx])) == 8'h00;
  endproperty
  a_absent_bits: assert property (p_absent_bits)
    else $error("absent register bits read nonzero");

  // Plain port write, then a read on the very next edge: the same byte
  // returns, so the port passes through to memory and keeps no copy
  sequence s_plain_write;
    ce_i && bus_i.we && mode == IND_PLAIN;
  endsequence
  sequence s_plain_read;
    ce_i && bus_i.re && mode == IND_PLAIN;
  endsequence
  property p_plain_readback;
    s_plain_write ##1 s_plain_read |=> rd_data_o == $past(bus_i.wdata, 2);
  endproperty
  a_plain_readback: assert property (p_plain_readback)
    else $error("plain port read back a different byte");

  // The indexed port uses the accumulator as an offset; no indirect access changes it
  property p_wacc_kept;
    (ce_i && access && is_ind)
      |=> working_accumulator_o == $past(working_accumulator_o);
  endproperty
  a_wacc_kept: assert property (p_wacc_kept)
    else $error("indirect access changed the accumulator");

  // Software writes land whole in the table pointer low byte
  property p_tbl_low_write;
    (ce_i && bus_i.we && slot_hit(bus_i.addr)
     && slot_idx == SLOT_W'(IDX_TBL_LO))
      |=> table_pointer_o[7:0] == $past(bus_i.wdata);
  endproperty
  a_tbl_low_write: assert property (p_tbl_low_write)
    else $error("table pointer low byte write lost");

  // The table latch is a full eight-bit holding byte
  property p_latch_write;
    (ce_i && bus_i.we && slot_hit(bus_i.addr)
     && slot_idx == SLOT_W'(IDX_TBL_LAT))
      |=> table_transfer_latch_o == $past(bus_i.wdata);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("table latch write lost");

  // A low clock enable freezes every stored byte; a strobe in such a
  // cycle is lost, so the core must repeat it once the enable returns
  property p_ce_freeze;
    !ce_i |=> st_q == $past(st_q);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("bank state moved while clock enable low");

  // Read data change only on the edge that takes a read strobe
  property p_rdata_hold;
    !(ce_i && bus_i.re) |=> $stable(rd_data_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

endmodule

// ### testbench/core_bus_model.sv
/*
 Instruction-core stand-in that drives the register port of the bank.
 Assumes one clock; strobes last one cycle and the slave never stalls.
*/
`timescale 1ns/100ps
module core_bus_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rd_data_i,
  output core_regs_pkg::bus_req_t bus_o,
  output logic ce_o
);
  import core_regs_pkg::*;

  // Idle bus and running clock enable from time zero
  initial begin
    bus_o = '0;
    ce_o = 1'b1;
  end

  // Clock enable changes only right after an edge
  task automatic set_ce(input logic v);
    @(posedge ref_clk_i);
    ce_o <= v;
  endtask

  // One write strobe; address and data scrambled once released so a
  // stale value can never pass for a live one
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus_o <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge ref_clk_i);
    bus_o <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
    #1;
  endtask

  // One read strobe; data stand from the cycle after the taken edge
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    bus_o <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge ref_clk_i);
    bus_o <= '{addr: ~a, wdata: 8'h00, we: 1'b0, re: 1'b0};
    #1;
    d = rd_data_i;
  endtask

  // Write then read the same address on back-to-back edges, no gap
  task automatic wr_rd(input logic [11:0] a, input logic [7:0] v,
                       output logic [7:0] d);
    @(posedge ref_clk_i);
    bus_o <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge ref_clk_i);
    bus_o <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge ref_clk_i);
    bus_o <= '{addr: ~a, wdata: 8'h00, we: 1'b0, re: 1'b0};
    #1;
    d = rd_data_i;
  endtask
endmodule

// ### testbench/tb_top.sv
/*
 Self-checking bench for the core register bank and its indirect ports.
 Assumes the bus model above as the only master and a 40 MHz clock.
*/
`timescale 1ns/100ps
module tb_top;
  import core_regs_pkg::*;

  logic ref_clk_i = 1'b0; // Bench clock
  logic arst_n_i = 1'b0; // Held low from time zero
  bus_req_t bus; // Request from the bus model
  logic ce; // Clock enable from the bus model
  logic [7:0] rd_data, tbl_lat, wacc, d;
  logic [21:0] tbl_ptr;
  logic cfg;
  int n_errors = 0;
  int total_checks = 0;
  logic [11:0] ra [7] = '{12'hff1, 12'hff0, 12'hffb, 12'hff6,
                          12'hff5, 12'hffc, 12'hfea};
  logic [7:0] rv [7] = '{8'hff, 8'hc0, 8'h20, 8'h00, 8'h00, 8'h00,
                         8'h00};

  // 25 ns period
  always #12.5 ref_clk_i = ~ref_clk_i;

  core_bus_model core_bus_model_inst (
    .ref_clk_i(ref_clk_i),
    .rd_data_i(rd_data),
    .bus_o(bus),
    .ce_o(ce)
  );

  core_register_file_indirect core_register_file_indirect_inst (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce),
    .bus_i(bus),
    .rd_data_o(rd_data),
    .table_pointer_o(tbl_ptr),
    .table_cfg_space_o(cfg),
    .table_transfer_latch_o(tbl_lat),
    .working_accumulator_o(wacc)
  );

  // Verdict in one place, reached by the main sequence or the watchdog
  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read one byte through the model and compare it
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    core_bus_model_inst.rd(a, d);
    chk({14'h0000, d}, {14'h0000, exp});
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    core_bus_model_inst.wr(a, v);
  endtask

  // Two cycles of reset, released right after an edge
  task automatic do_reset();
    arst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    do_reset();
    // Reset values, table pointer and latch cleared
    for (int i = 0; i < 7; i++) begin
      rchk(ra[i], rv[i]);
    end
    chk(tbl_ptr, 22'h00_0000);
    chk({14'h0000, tbl_lat}, 22'h00_0000);
    chk({21'h00_0000, cfg}, 22'h00_0000);
    // Dirty the reset-cleared bytes and the product, then reset mid-run
    wr(12'hff7, 8'h12);
    wr(12'hff6, 8'h77);
    wr(12'hff5, 8'h88);
    wr(12'hff4, 8'h5a);
    chk(tbl_ptr, 22'h00_1277);
    chk({14'h0000, tbl_lat}, 22'h00_0088);
    do_reset();
    chk(tbl_ptr, 22'h00_0000);
    chk({14'h0000, tbl_lat}, 22'h00_0000);
    rchk(12'hff6, 8'h00);
    rchk(12'hff5, 8'h00);
    rchk(12'hff4, 8'h5a);
    // Absent places and absent bits read zero
    rchk(12'hfe0, 8'h00);
    rchk(12'hf00, 8'h00);
    wr(12'hfff, 8'hff);
    rchk(12'hfff, 8'h1f);
    // Pointer bit 21 steers table accesses
    wr(12'hff8, 8'h20);
    chk({21'h00_0000, cfg}, 22'h00_0001);
    chk(tbl_ptr, 22'h20_0000);
    wr(12'hff8, 8'hdf);
    chk({21'h00_0000, cfg}, 22'h00_0000);
    rchk(12'hff8, 8'h1f);
    // Strobes with the clock enable low are ignored
    core_bus_model_inst.set_ce(1'b0);
    wr(12'hff7, 8'h99);
    core_bus_model_inst.set_ce(1'b1);
    rchk(12'hff7, 8'h00);
    // Indirect ports around pointer 0x123
    wr(12'hfea, 8'h01);
    wr(12'hfe9, 8'h23);
    wr(12'hfef, 8'haa);
    rchk(12'hfe9, 8'h23);
    rchk(12'hfef, 8'haa);
    wr(12'hfee, 8'hbb);
    rchk(12'hfe9, 8'h24);
    wr(12'hfed, 8'hcc);
    rchk(12'hfe9, 8'h23);
    rchk(12'hfec, 8'hcc);
    rchk(12'hfe9, 8'h24);
    wr(12'hfe8, 8'hff);
    rchk(12'hfeb, 8'hbb);
    rchk(12'hfe9, 8'h24);
    rchk(12'hfee, 8'hcc);
    rchk(12'hfe9, 8'h25);
    // Wrap at the top of data memory, both directions
    wr(12'hfea, 8'h0f);
    wr(12'hfe9, 8'hff);
    wr(12'hfee, 8'h5c);
    rchk(12'hfea, 8'h00);
    wr(12'hfed, 8'h11);
    rchk(12'hfea, 8'h0f);
    rchk(12'hfef, 8'h5c);
    wr(12'hfe8, 8'h01);
    chk({14'h0000, wacc}, 22'h00_0001);
    rchk(12'hfeb, 8'h11);
    rchk(12'hfe9, 8'hff);
    rchk(12'hfea, 8'h0f);
    wr(12'hfe9, 8'hfe);
    rchk(12'hfec, 8'h5c);
    // Back-to-back strobes, and the write and read modes not yet used
    core_bus_model_inst.wr_rd(12'hfef, 8'h6d, d);
    chk({14'h0000, d}, 22'h00_006d);
    wr(12'hfec, 8'h42);
    rchk(12'hfea, 8'h00);
    rchk(12'hfed, 8'h42);
    rchk(12'hfea, 8'h0f);
    wr(12'hfeb, 8'h24);
    rchk(12'hfef, 8'h6d);
    rchk(12'hfeb, 8'h24);
    core_bus_model_inst.wr_rd(12'hff4, 8'ha5, d);
    chk({14'h0000, d}, 22'h00_00a5);
    tally_and_finish();
  end
endmodule
